// File: hdl/sadc_pkg.sv
// How it works
// - The two clock-select bits 7:6 pick the conversion clock: oscillator over 2, 8 or 32, or the internal RC clock.
// - Channel bits 5:3 pick the input: codes 0 to 3 are port A lines 0 to 3, code 4 is port A line 5, codes 5 to 7 are port E lines 0 to 2.
// - Channels 5 to 7 exist only on the eight-input build; the five-input build offers channels 0 to 4.
// - Writing one to bit 2 with bit 0 also one in the same write starts a conversion, and the bit reads one while it runs.
// - Hardware clears bit 2 by itself when the conversion ends, and zero means idle.
// - The converter runs only while bit 0 is one; at zero it is shut off.
// - Conversion can go on during sleep, provided the internal RC clock is selected.
// - The held sample becomes an 8-bit result by successive approximation.
// - Software picks the reference: the positive supply or the port A line 3 reference pin.
// - There are three registers: result, main control and pin configuration.
// - The pin configuration register sets each shared pin as analog input or digital I/O, with port A line 3 also usable as reference.
// - The pin configuration sits in bits 2:0 of that register; all ones makes every shared pin digital.
package sadc_pkg;
	// Register offsets, word indices on a 32-bit bus
	localparam logic [7:0] SADC_OFF_RESULT  = 8'h1e;
	localparam logic [7:0] SADC_OFF_CONTROL = 8'h1f;
	localparam logic [7:0] SADC_OFF_PINCFG  = 8'h9f;
	// Offsets 1e/1f/9f are not word aligned: index times four
	localparam logic [9:0] SADC_ADR_RESULT  = {SADC_OFF_RESULT, 2'b00};
	localparam logic [9:0] SADC_ADR_CONTROL = {SADC_OFF_CONTROL, 2'b00};
	localparam logic [9:0] SADC_ADR_PINCFG  = {SADC_OFF_PINCFG, 2'b00};
	// Control field positions
	localparam int SADC_CLK_HI  = 7;
	localparam int SADC_CLK_LO  = 6;
	localparam int SADC_CHN_HI  = 5;
	localparam int SADC_CHN_LO  = 3;
	localparam int SADC_GO_BIT  = 2;
	localparam int SADC_ON_BIT  = 0;
	localparam int SADC_PCF_HI  = 2;
	localparam int SADC_VREF_BIT = 3;
	// Reset values
	localparam logic [7:0] SADC_RST_CONTROL = 8'h00;
	localparam logic [7:0] SADC_RST_PINCFG  = 8'h00;
	localparam logic [7:0] SADC_RST_RESULT  = 8'h00;
	localparam logic [7:0] SADC_CONTROL_MASK = 8'hfd;
	localparam logic [7:0] SADC_PINCFG_MASK  = 8'h0f;
	// Clock select codes
	localparam logic [1:0] SADC_CLK_DIV2  = 2'h0;
	localparam logic [1:0] SADC_CLK_DIV8  = 2'h1;
	localparam logic [1:0] SADC_CLK_DIV32 = 2'h2;
	localparam logic [1:0] SADC_CLK_RC    = 2'h3;
	localparam logic [4:0] SADC_DIV2_MAX  = 5'h01;
	localparam logic [4:0] SADC_DIV8_MAX  = 5'h07;
	localparam logic [4:0] SADC_DIV32_MAX = 5'h1f;
	// Conversion sequence
	localparam logic [3:0] SADC_BITS      = 4'h8;
	localparam logic [3:0] SADC_ACQ_TICKS = 4'h2;
	localparam logic [2:0] SADC_PCF_ALLDIG = 3'h7;
	typedef enum logic [1:0] {
		SADC_IDLE = 2'b00,
		SADC_ACQ  = 2'b01,
		SADC_CONV = 2'b11,
		SADC_DONE = 2'b10
	} sadc_state_e;
endpackage

// File: hdl/sadc_tick.sv
`timescale 1ns/10ps
`default_nettype none
// Conversion clock enable from the oscillator or the RC clock input
module sadc_tick
	import sadc_pkg::*;
(
	// System
	input  wire logic       clk,
	input  wire logic       rst,
	// Control
	input  wire logic       run,
	input  wire logic [1:0] sel,
	input  wire logic       rc_tick,
	// Enable out
	output logic            tick
);
	logic [4:0] cnt_r;
	logic [4:0] cnt_max;

	// Terminal count per divider code
	assign cnt_max = (sel == SADC_CLK_DIV2) ? SADC_DIV2_MAX :
			 (sel == SADC_CLK_DIV8) ? SADC_DIV8_MAX : SADC_DIV32_MAX;

	// Counter held at zero when idle to save switching
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			cnt_r <= 5'h00;
			tick  <= 1'b0;
		end else if (sel == SADC_CLK_RC) begin
			cnt_r <= 5'h00;
			tick  <= rc_tick;
		end else begin
			tick  <= (cnt_r == cnt_max);
			cnt_r <= (cnt_r == cnt_max) ? 5'h00 : cnt_r + 5'h01;
		end
	end
endmodule // sadc_tick
`default_nettype wire

// File: hdl/sadc_sar.sv
`timescale 1ns/10ps
`default_nettype none
// Successive approximation register, one bit decided per tick
module sadc_sar
	import sadc_pkg::*;
(
	// System
	input  wire logic       clk,
	input  wire logic       rst,
	// Sequence
	input  wire logic       load,
	input  wire logic       step,
	input  wire logic       cmp_hi,
	// Result
	output logic [7:0]      trial,
	output logic            last
);
	logic [7:0] mask_r;
	logic [7:0] val_r;

	assign trial = val_r | mask_r;
	assign last  = mask_r[0];

	// Keep the trial bit if the input sits above the DAC level
	always_ff @(posedge clk) begin
		if (rst || load) begin
			mask_r <= 8'h80;
			val_r  <= 8'h00;
		end else if (step && (mask_r != 8'h00)) begin
			val_r  <= cmp_hi ? (val_r | mask_r) : val_r;
			mask_r <= {1'b0, mask_r[7:1]};
		end
	end
endmodule // sadc_sar
`default_nettype wire

// File: hdl/sadc_top.sv
`timescale 1ns/10ps
`default_nettype none
// Converter control: Wishbone slave, clock select, channel mux, SAR sequence
module sadc_top
	import sadc_pkg::*;
#(
	parameter bit EIGHT_INPUTS = 1'b1
)
(
	// System
	input  wire logic        CLK,
	input  wire logic        RST,
	// Wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [9:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK_O,
	// Analog front end
	input  wire logic        RC_TICK,
	input  wire logic        CMP_HI,
	output logic [7:0]       DAC_CODE,
	output logic             SAMPLE_EN,
	output logic             ADC_POWER,
	output logic [2:0]       AMUX_SEL,
	output logic             VREF_PIN_SEL,
	output logic [7:0]       ANALOG_PIN_EN
);
	sadc_state_e state_r;
	sadc_state_e state_nxt;
	logic [7:0] control_r;
	logic [7:0] pincfg_r;
	logic [7:0] result_r;
	logic [3:0] acq_cnt_r;
	logic       tick;
	logic       last;
	logic [7:0] trial;
	logic       wb_req;
	logic       wr_control;
	logic       wr_pincfg;
	logic       go_set;
	logic       conv_end;
	logic       power_on;
	logic [2:0] chan;
	logic [7:0] rd_data;
	logic [7:0] ctl_write;
	logic [7:0] pin_mask;

	// Bytes narrower than the bus live in lane 0
	function automatic logic [7:0] lane0(input logic [31:0] d, input logic [7:0] keep);
		lane0 = d[7:0] & keep;
	endfunction

	// Analog pin enable per configuration code; high bits are port E
	function automatic logic [7:0] pcfg_decode(input logic [2:0] code, input logic eight);
		logic [7:0] m;
		m = 8'h00;
		unique case (code)
			3'h0, 3'h1: m = 8'hff;
			3'h2, 3'h3: m = 8'h1f;
			3'h4, 3'h5: m = 8'h0b;
			3'h6, 3'h7: m = 8'h00;
		endcase
		if (code == SADC_PCF_ALLDIG)
			m = 8'h00;
		if (!eight)
			m = m & 8'h1f;
		pcfg_decode = m;
	endfunction

	// Bus decode; the slave answers one cycle after the strobe
	assign wb_req     = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wr_control = wb_req && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == SADC_ADR_CONTROL);
	assign wr_pincfg  = wb_req && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == SADC_ADR_PINCFG);
	assign ctl_write  = lane0(WB_DAT_I, SADC_CONTROL_MASK);
	assign power_on   = control_r[SADC_ON_BIT];
	assign go_set     = wr_control && ctl_write[SADC_GO_BIT] && ctl_write[SADC_ON_BIT];
	assign conv_end   = (state_r == SADC_DONE);
	// Upper channels fold back to channel 0 on five-input parts
	assign chan       = (!EIGHT_INPUTS && control_r[SADC_CHN_HI] &&
			     (control_r[SADC_CHN_HI-1:SADC_CHN_LO] != 2'h0)) ?
			    3'h0 : control_r[SADC_CHN_HI:SADC_CHN_LO];
	assign pin_mask   = pcfg_decode(pincfg_r[SADC_PCF_HI:0], EIGHT_INPUTS);

	// Read mux; unmapped addresses read zero and are still acked
	assign rd_data = (WB_ADR_I == SADC_ADR_RESULT)  ? result_r :
			 (WB_ADR_I == SADC_ADR_CONTROL) ? control_r :
			 (WB_ADR_I == SADC_ADR_PINCFG)  ? pincfg_r : 8'h00;

	// Bus answer registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= wb_req;
			WB_DAT_O <= wb_req ? {24'h00_0000, rd_data} : 32'h0000_0000;
		end
	end

	sadc_tick u_tick (
		.clk     (CLK),
		.rst     (RST),
		.run     (power_on && (state_r != SADC_IDLE)),
		.sel     (control_r[SADC_CLK_HI:SADC_CLK_LO]),
		.rc_tick (RC_TICK),
		.tick    (tick)
	);

	sadc_sar u_sar (
		.clk    (CLK),
		.rst    (RST),
		.load   (state_r == SADC_IDLE),
		.step   (tick && (state_r == SADC_CONV)),
		.cmp_hi (CMP_HI),
		.trial  (trial),
		.last   (last)
	);

	// Sequencer: acquire, then eight compare steps, then finish
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SADC_IDLE: if (go_set) state_nxt = SADC_ACQ;
			SADC_ACQ:  if (tick && acq_cnt_r == SADC_ACQ_TICKS - 4'h1) state_nxt = SADC_CONV;
			SADC_CONV: if (tick && last) state_nxt = SADC_DONE;
			SADC_DONE: state_nxt = SADC_IDLE;
		endcase
		// A write that powers up and starts at once must not be cancelled by the old bit
		if (!power_on && !go_set)
			state_nxt = SADC_IDLE;
	end

	// State and acquisition counter
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r   <= SADC_IDLE;
			acq_cnt_r <= 4'h0;
		end else begin
			state_r   <= state_nxt;
			acq_cnt_r <= (state_r == SADC_ACQ) ? acq_cnt_r + {3'h0, tick} : 4'h0;
		end
	end

	// Control register; done clears go, result loads on the same edge
	always_ff @(posedge CLK) begin
		if (RST) begin
			control_r <= SADC_RST_CONTROL;
			result_r  <= SADC_RST_RESULT;
		end else begin
			if (wr_control)
				control_r <= ctl_write;
			if (conv_end) begin
				control_r[SADC_GO_BIT] <= 1'b0;
				result_r <= trial;
			end else if (!power_on && !go_set)
				control_r[SADC_GO_BIT] <= 1'b0;
		end
	end

	// Pin configuration register, bit 3 picks the reference pin
	always_ff @(posedge CLK) begin
		if (RST)
			pincfg_r <= SADC_RST_PINCFG;
		else if (wr_pincfg)
			pincfg_r <= lane0(WB_DAT_I, SADC_PINCFG_MASK);
	end

	// Registered analog outputs
	always_ff @(posedge CLK) begin
		if (RST) begin
			DAC_CODE      <= 8'h00;
			SAMPLE_EN     <= 1'b0;
			ADC_POWER     <= 1'b0;
			AMUX_SEL      <= 3'h0;
			VREF_PIN_SEL  <= 1'b0;
			ANALOG_PIN_EN <= 8'h00;
		end else begin
			DAC_CODE      <= trial;
			SAMPLE_EN     <= power_on && (state_nxt == SADC_ACQ);
			ADC_POWER     <= power_on;
			AMUX_SEL      <= chan;
			VREF_PIN_SEL  <= pincfg_r[SADC_VREF_BIT] && pin_mask[3];
			ANALOG_PIN_EN <= pin_mask;
		end
	end
endmodule // sadc_top
`default_nettype wire

// File: testbench/sadc_afe.sv
`timescale 1ns/10ps
`default_nettype none
// Analog side: input pins, hold stage, comparator and RC oscillator
module sadc_afe #(
	parameter int RC_PER = 6
)
(
	// System
	input  wire logic       clk,
	// From the converter
	input  wire logic       pwr,
	input  wire logic       sample,
	input  wire logic [2:0] ch,
	input  wire logic [7:0] dac,
	// To the converter
	output logic            rc_tick,
	output logic            cmp_hi
);
	logic [7:0] held_r = 8'h00;
	logic       tog_r  = 1'b0;
	int         cnt_r  = 0;
	// Hold stage tracks the chosen pin only while sampling
	always_ff @(posedge clk) begin
		if (sample)
			held_r <= 8'h24 * ch + 8'h03;
		tog_r <= ~tog_r;
		cnt_r <= (cnt_r == RC_PER - 1) ? 0 : cnt_r + 1;
	end
	// RC oscillator runs free, also in sleep
	assign rc_tick = (cnt_r == 0);
	// Level sits half a step above its code, so a tie reads high; off means no valid level
	assign cmp_hi = pwr ? (held_r >= dac) : tog_r;
endmodule // sadc_afe
`default_nettype wire

// File: testbench/sadc_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Port checker for the converter control block
module sadc_chk
	import sadc_pkg::*;
#(
	parameter bit EIGHT_INPUTS = 1'b1
)
(
	// System
	input wire logic        CLK, RST,
	// Wishbone
	input wire logic        WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O,
	input wire logic [9:0]  WB_ADR_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [31:0] WB_DAT_I, WB_DAT_O,
	// Analog front end
	input wire logic        RC_TICK, CMP_HI, SAMPLE_EN, ADC_POWER, VREF_PIN_SEL,
	input wire logic [7:0]  DAC_CODE, ANALOG_PIN_EN,
	input wire logic [2:0]  AMUX_SEL
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// Accepted requests and register writes
	wire take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	wire wr = take & WB_WE_I & WB_SEL_I[0];
	wire wr_ctl = wr & (WB_ADR_I == SADC_ADR_CONTROL);
	wire wr_pcf = wr & (WB_ADR_I == SADC_ADR_PINCFG);
	a_ack_answer: assert property (take |=> WB_ACK_O) else $error("no ack");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
	a_power_follow: assert property (wr_ctl |=> ##1 ADC_POWER == $past(WB_DAT_I[0], 2))
		else $error("power bit not followed");
	a_mux_follow: assert property (wr_ctl |=> ##1 AMUX_SEL == ((EIGHT_INPUTS ||
		$past(WB_DAT_I[5:3], 2) < 3'h5) ? $past(WB_DAT_I[5:3], 2) : 3'h0))
		else $error("bad channel");
	a_pin_digital: assert property (wr_pcf && WB_DAT_I[2:0] == 3'h7 |=> ##1
		ANALOG_PIN_EN == 8'h00) else $error("pins left analog");
	a_off_idle: assert property (!ADC_POWER |-> !SAMPLE_EN) else $error("sampling off");
	a_ctl_bit1: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == SADC_ADR_CONTROL
		|-> WB_DAT_O[1] == 1'b0 && WB_DAT_O[31:8] == 24'h0) else $error("bit 1 set");
	a_vref_pin: assert property (VREF_PIN_SEL |-> ANALOG_PIN_EN[3])
		else $error("reference pin not analog");
	c_start: cover property (wr_ctl && WB_DAT_I[2] && WB_DAT_I[0]);
	c_sample: cover property ($fell(SAMPLE_EN));
	c_vref: cover property (VREF_PIN_SEL);
endmodule // sadc_chk
bind sadc_top sadc_chk #(.EIGHT_INPUTS(EIGHT_INPUTS)) sadc_chk_i (.CLK(CLK), .RST(RST),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ACK_O(WB_ACK_O),
	.WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
	.RC_TICK(RC_TICK), .CMP_HI(CMP_HI), .SAMPLE_EN(SAMPLE_EN), .ADC_POWER(ADC_POWER),
	.VREF_PIN_SEL(VREF_PIN_SEL), .DAC_CODE(DAC_CODE), .ANALOG_PIN_EN(ANALOG_PIN_EN),
	.AMUX_SEL(AMUX_SEL));
`default_nettype wire

// File: testbench/test_sar_adc_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_control
	import sadc_pkg::*;
;
	localparam int RC_PER = 6;
	logic        clk, rst, cyc, stb, we, ack, rc, cmp, smp, pwr, vref;
	logic [9:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, dout;
	logic [7:0]  dac, pen;
	logic [2:0]  mux;
	logic [7:0]  pen5;
	logic [2:0]  mux5;
	int          err_count = 0;
	int          checks = 0;
	sadc_top #(.EIGHT_INPUTS(1'b1)) sadc_top_i (.CLK(clk), .RST(rst), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
		.WB_DAT_O(dout), .WB_ACK_O(ack), .RC_TICK(rc), .CMP_HI(cmp), .DAC_CODE(dac),
		.SAMPLE_EN(smp), .ADC_POWER(pwr), .AMUX_SEL(mux), .VREF_PIN_SEL(vref),
		.ANALOG_PIN_EN(pen));
	sadc_afe #(.RC_PER(RC_PER)) sadc_afe_i (.clk(clk), .pwr(pwr), .sample(smp), .ch(mux),
		.dac(dac), .rc_tick(rc), .cmp_hi(cmp));
	// Five-input build on the same bus; only its channel and pin outputs are judged
	sadc_top #(.EIGHT_INPUTS(1'b0)) sadc_top_i5 (.CLK(clk), .RST(rst), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
		.WB_DAT_O(), .WB_ACK_O(), .RC_TICK(rc), .CMP_HI(cmp), .DAC_CODE(),
		.SAMPLE_EN(), .ADC_POWER(), .AMUX_SEL(mux5), .VREF_PIN_SEL(),
		.ANALOG_PIN_EN(pen5));
	// Free running 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask
	// Classic single cycle; held until ack is sampled, then released for one cycle
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			results();
		end
		q = dout[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_regs();
		logic [7:0] q;
		wb(1'b0, SADC_ADR_CONTROL, 8'h00, q); chk("control", 8'h00, q);
		wb(1'b0, SADC_ADR_RESULT, 8'h00, q); chk("result", 8'h00, q);
		wb(1'b0, SADC_ADR_PINCFG, 8'h00, q); chk("pincfg", 8'h00, q);
		wb(1'b1, 10'h3f0, 8'h55, q);
		wb(1'b0, 10'h3f0, 8'h00, q); chk("unmapped", 8'h00, q);
		wb(1'b1, SADC_ADR_CONTROL, 8'hfa, q);
		wb(1'b0, SADC_ADR_CONTROL, 8'h00, q); chk("bit 1", 8'hf8, q);
		$display("regs done");
	endtask
	// Start, poll until idle, then judge the pace and the code
	task automatic t_conv(input logic [1:0] c, input logic [2:0] ch);
		logic [7:0] q;
		int n;
		int per;
		per = (c == 2'h0) ? 2 : (c == 2'h1) ? 8 : (c == 2'h2) ? 32 : RC_PER;
		wb(1'b1, SADC_ADR_CONTROL, {c, ch, 3'b101}, q);
		wb(1'b0, SADC_ADR_CONTROL, 8'h00, q); chk("busy", {c, ch, 3'b101}, q);
		chk("channel", {5'h0, ch}, {5'h0, mux});
		chk("channel five", {5'h0, (ch < 3'h5) ? ch : 3'h0}, {5'h0, mux5});
		chk("power", 8'h01, {7'h0, pwr});
		n = 0;
		while (q[2] === 1'b1 && n < 400) begin
			wb(1'b0, SADC_ADR_CONTROL, 8'h00, q);
			n++;
		end
		chk("done", {c, ch, 3'b001}, q);
		chk("pace", 8'h01, {7'h0, 3 * n >= 9 * per && 3 * n <= 11 * per + 12});
		wb(1'b0, SADC_ADR_RESULT, 8'h00, q); chk("code", 8'h24 * ch + 8'h03, q);
		chk("sample", 8'h00, {7'h0, smp});
		$display("conversion %0d done", ch);
	endtask
	// Power off mid conversion: idle at once, old result kept
	task automatic t_abort();
		logic [7:0] q;
		wb(1'b1, SADC_ADR_CONTROL, 8'h95, q);
		wb(1'b1, SADC_ADR_CONTROL, 8'h90, q);
		repeat (8) @(posedge clk);
		wb(1'b0, SADC_ADR_CONTROL, 8'h00, q); chk("off", 8'h90, q);
		chk("power off", 8'h00, {7'h0, pwr});
		wb(1'b0, SADC_ADR_RESULT, 8'h00, q); chk("kept", 8'hff, q);
		$display("abort done");
	endtask
	task automatic t_pins();
		logic [7:0] q;
		wb(1'b1, SADC_ADR_PINCFG, 8'hf7, q);
		wb(1'b0, SADC_ADR_PINCFG, 8'h00, q); chk("pincfg", 8'h07, q);
		chk("digital", 8'h00, pen);
		chk("digital five", 8'h00, pen5);
		wb(1'b1, SADC_ADR_PINCFG, 8'h08, q);
		chk("analog", 8'hff, pen);
		chk("analog five", 8'h1f, pen5);
		chk("ref pin", 8'h01, {7'h0, vref});
		$display("pins done");
	endtask
	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 10'h000;
		sel = 4'hf;
		dat = 32'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		for (int i = 0; i < 8; i++)
			t_conv(i[1:0], i[2:0]);
		t_abort();
		t_pins();
		results();
	end
endmodule // test_sar_adc_control
`default_nettype wire
